/* core/adsq_pkg.sv */
// package for the converter selection sequencer: register map, field
// positions, reset values, conversion timing and the state carrier.
// assumes a 100 mhz mclk and a 32-bit apb slave with word-aligned registers.
package adsq_pkg;

  // register byte offsets
  localparam logic [7:0] ADSQ_CTRL_OFS = 8'h00;
  localparam logic [7:0] ADSQ_SEL_OFS = 8'h04;
  localparam logic [7:0] ADSQ_RESULT_OFS = 8'h08;
  localparam logic [7:0] ADSQ_STATUS_OFS = 8'h0c;

  // converter_control_status field positions
  localparam int ADSQ_CTRL_PRESC_LSB = 0;
  localparam int ADSQ_CTRL_IRQ_EN_BIT = 3;
  localparam int ADSQ_CTRL_DONE_BIT = 4;
  localparam int ADSQ_CTRL_FREE_BIT = 5;
  localparam int ADSQ_CTRL_START_BIT = 6;
  localparam int ADSQ_CTRL_ENABLE_BIT = 7;

  // selection_register field positions
  localparam int ADSQ_SEL_CHAN_LSB = 0;
  localparam int ADSQ_SEL_REF_LSB = 6;

  // reference_select encodings
  localparam logic [1:0] ADSQ_REF_EXT_PIN = 2'h0;
  localparam logic [1:0] ADSQ_REF_SUPPLY = 2'h1;
  localparam logic [1:0] ADSQ_REF_RESERVED = 2'h2;
  localparam logic [1:0] ADSQ_REF_INT_2V56 = 2'h3;

  // conversion timing in converter clock cycles, and sample points
  localparam logic [4:0] ADSQ_NORMAL_CYCLES = 5'd13;
  localparam logic [4:0] ADSQ_FIRST_CYCLES = 5'd25;
  localparam logic [4:0] ADSQ_NORMAL_SAMPLE = 5'd1;
  localparam logic [4:0] ADSQ_FIRST_SAMPLE = 5'd13;

  // full-scale code, reset values
  localparam logic [9:0] ADSQ_FULL_SCALE = 10'h3ff;
  localparam logic [7:0] ADSQ_CTRL_RESET = 8'h00;
  localparam logic [7:0] ADSQ_SEL_RESET = 8'h00;

  // sleep mode codes presented by the core
  typedef enum logic [2:0] {
    ADSQ_SLEEP_IDLE, ADSQ_SLEEP_NOISE, ADSQ_SLEEP_PSAVE,
    ADSQ_SLEEP_PDOWN, ADSQ_SLEEP_STANDBY
  } adsq_sleep_type;

  typedef enum logic [1:0] {ADSQ_IDLE, ADSQ_WAIT_EDGE, ADSQ_CONV} adsq_phase_type;

  // apb request as seen by the slave
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } adsq_apb_req_type;

  // whole state of the sequencer
  typedef struct packed {
    adsq_phase_type phase;
    logic [1:0] ref_hold;
    logic [3:0] chan_hold;
    logic [1:0] ref_act;
    logic [3:0] chan_act;
    logic enable;
    logic start;
    logic free_run;
    logic done;
    logic irq_en;
    logic [2:0] presc;
    logic first;
    logic [6:0] div_cnt;
    logic [4:0] cyc;
    logic [9:0] sampled;
    logic [9:0] result;
    logic [10:0] code_s1;
    logic [10:0] code_s2;
    logic [31:0] prdata;
  } adsq_state_type;

endpackage

/* core/adsq_sequencer.sv */
// converter selection sequencer: holding/active selection, prescaled
// converter clock, single and free-running conversions, sleep start.
// assumes an apb master on mclk and an analog front end that delivers an
// 11-bit code of the input relative to the active reference (may exceed).
// assumes sleep entry and interrupt acknowledge are pulses on mclk.

module adsq_sequencer
  import adsq_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [10:0] analog_code,
  input wire logic sleep_enter,
  input wire adsq_sleep_type sleep_mode,
  input wire logic irq_ack,
  output logic [3:0] active_channel,
  output logic [1:0] active_reference,
  output logic internal_ref_on,
  output logic converter_busy,
  output logic conv_irq
);
  timeunit 1ns;
  timeprecision 1ps;

  // whole state register and its next value
  adsq_state_type st_ff;
  adsq_state_type nxt_st;
  adsq_apb_req_type req;

  // decoded bus and timing helpers
  logic wr_acc;
  logic setup;
  logic tick;
  logic [4:0] conv_len;
  logic [4:0] sample_at;
  logic [7:0] ctrl_rd;
  logic mapped;
  logic conv_last;

  // division factor minus one for the prescaler select; selects 0 and 1
  // both divide by two
  function automatic logic [6:0] div_last(input logic [2:0] sel);
    logic [6:0] d;
    d = 7'h01;
    case (sel)
      3'h0: d = 7'h01;
      3'h1: d = 7'h01;
      3'h2: d = 7'h03;
      3'h3: d = 7'h07;
      3'h4: d = 7'h0f;
      3'h5: d = 7'h1f;
      3'h6: d = 7'h3f;
      3'h7: d = 7'h7f;
      default: d = 7'h01;
    endcase
    return d;
  endfunction

  // clamp a code above the reference to full scale; bit 10 of the code
  // flags an input above the reference, so the result never wraps low
  function automatic logic [9:0] clamp_code(input logic [10:0] c);
    logic [9:0] r;
    r = c[9:0];
    if (c[10]) begin
      r = ADSQ_FULL_SCALE;
    end
    return r;
  endfunction

  // selection fields in register order, for the holding and the active copy
  function automatic logic [7:0] sel_word(input logic [1:0] r, input logic [3:0] c);
    return {r, 2'h0, c};
  endfunction

  // only the four register words answer without an error
  function automatic logic is_mapped(input logic [7:0] a);
    return (a == ADSQ_CTRL_OFS) || (a == ADSQ_SEL_OFS) ||
           (a == ADSQ_RESULT_OFS) || (a == ADSQ_STATUS_OFS);
  endfunction

  // bus request gathered into one carrier
  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr,
                 pwdata: pwdata};
  assign mapped = is_mapped(req.paddr);
  assign setup = req.psel & ~req.penable;
  assign wr_acc = req.psel & req.penable & req.pwrite & mapped;

  // zero wait states: read data is latched in the setup cycle
  // unmapped offsets answer with pslverr and their writes are dropped
  assign pready = 1'b1;
  assign pslverr = req.psel & req.penable & ~mapped;
  assign prdata = st_ff.prdata;

  // converter clock enable: one pulse per division period while enabled;
  // the divider is held at zero while disabled, so the first pulse after
  // enabling comes one whole division period later
  assign tick = st_ff.enable && (st_ff.div_cnt == div_last(st_ff.presc));
  assign conv_len = st_ff.first ? ADSQ_FIRST_CYCLES : ADSQ_NORMAL_CYCLES;
  assign sample_at = st_ff.first ? ADSQ_FIRST_SAMPLE : ADSQ_NORMAL_SAMPLE;
  // last converter cycle of a run, the one cycle of a run that tracks
  assign conv_last = (st_ff.phase == ADSQ_CONV) && (st_ff.cyc == conv_len);

  // control word in register bit order
  assign ctrl_rd = {st_ff.enable, st_ff.start, st_ff.free_run, st_ff.done,
                    st_ff.irq_en, st_ff.presc};

  // all next-state logic
  always_comb begin
    logic lock;
    logic complete;
    logic done_set;
    logic done_clr;
    logic wr_start;
    logic sleep_go;
    nxt_st = st_ff;
    lock = 1'b0;
    complete = 1'b0;
    done_set = 1'b0;
    done_clr = 1'b0;
    wr_start = 1'b0;
    sleep_go = 1'b0;

    // analog code crosses in through two flops; a code that moves while it
    // is taken can tear across bits, so the front end holds it steady
    // around the sample point
    nxt_st.code_s1 = analog_code;
    nxt_st.code_s2 = st_ff.code_s1;

    // prescaler counts only while enabled, held at zero otherwise
    if (!st_ff.enable || tick) begin
      nxt_st.div_cnt = 7'h00;
    end else begin
      nxt_st.div_cnt = st_ff.div_cnt + 7'h01;
    end

    // software writes
    if (wr_acc && req.paddr == ADSQ_SEL_OFS) begin
      nxt_st.ref_hold = req.pwdata[ADSQ_SEL_REF_LSB +: 2];
      nxt_st.chan_hold = req.pwdata[ADSQ_SEL_CHAN_LSB +: 4];
    end
    if (wr_acc && req.paddr == ADSQ_CTRL_OFS) begin
      nxt_st.enable = req.pwdata[ADSQ_CTRL_ENABLE_BIT];
      nxt_st.free_run = req.pwdata[ADSQ_CTRL_FREE_BIT];
      nxt_st.irq_en = req.pwdata[ADSQ_CTRL_IRQ_EN_BIT];
      nxt_st.presc = req.pwdata[ADSQ_CTRL_PRESC_LSB +: 3];
      wr_start = req.pwdata[ADSQ_CTRL_START_BIT] & req.pwdata[ADSQ_CTRL_ENABLE_BIT];
      done_clr = req.pwdata[ADSQ_CTRL_DONE_BIT];
    end
    if (irq_ack) begin
      done_clr = 1'b1;
    end

    // sleep start only in idle or noise mode; other modes leave all as is
    // the core is halted then, so no bus write races the sleep start
    sleep_go = sleep_enter && st_ff.enable && (st_ff.phase == ADSQ_IDLE) &&
               !st_ff.start && !st_ff.free_run && st_ff.irq_en &&
               (sleep_mode == ADSQ_SLEEP_IDLE || sleep_mode == ADSQ_SLEEP_NOISE);

    case (st_ff.phase)
      ADSQ_IDLE: begin
        // software and sleep starts alike wait for a converter edge
        if (wr_start || sleep_go) begin
          nxt_st.start = 1'b1;
          nxt_st.phase = ADSQ_WAIT_EDGE;
        end
      end
      ADSQ_WAIT_EDGE: begin
        // the start waits for the next converter clock edge
        // a start written just after a pulse waits almost a whole period
        if (tick) begin
          nxt_st.phase = ADSQ_CONV;
          nxt_st.cyc = 5'd1;
          lock = 1'b1;
        end
      end
      ADSQ_CONV: begin
        // frozen until the last converter cycle before completion; that one
        // cycle tracks, so a free-running restart locks the newest selection
        lock = !conv_last;
        if (tick) begin
          if (st_ff.cyc == sample_at) begin
            nxt_st.sampled = clamp_code(st_ff.code_s2);
          end
          if (st_ff.cyc == conv_len) begin
            complete = 1'b1;
            nxt_st.first = 1'b0;
            nxt_st.result = st_ff.sampled;
            done_set = 1'b1;
            if (st_ff.free_run) begin
              // next run starts at once; it locks what was tracked so far
              // a selection written from here on waits for the run after it
              nxt_st.cyc = 5'd1;
              lock = 1'b1;
            end else begin
              nxt_st.start = 1'b0;
              nxt_st.phase = ADSQ_IDLE;
            end
          end else begin
            nxt_st.cyc = st_ff.cyc + 5'd1;
          end
        end
      end
      default: begin
        nxt_st.phase = ADSQ_IDLE;
      end
    endcase

    // tracking of the active copy, every mclk while unlocked or disabled;
    // running at mclk rather than the converter rate costs nothing and
    // keeps the status view current
    if (!lock || !st_ff.enable) begin
      nxt_st.ref_act = st_ff.ref_hold;
      nxt_st.chan_act = st_ff.chan_hold;
    end

    // disabling aborts any conversion and rearms the long first run
    // a run cut short this way leaves result and done untouched
    if (!nxt_st.enable) begin
      nxt_st.phase = ADSQ_IDLE;
      nxt_st.start = 1'b0;
      nxt_st.first = 1'b1;
      nxt_st.cyc = 5'd0;
    end

    // a completion in the clearing cycle is kept: set wins
    // so an acknowledge landing on the completion edge never hides a result
    if (done_set) begin
      nxt_st.done = 1'b1;
    end else if (done_clr) begin
      nxt_st.done = 1'b0;
    end

    // read data captured in the setup cycle, so the access phase answers at
    // once; a read that meets a completion edge returns the older result
    if (setup && !req.pwrite) begin
      case (req.paddr)
        ADSQ_CTRL_OFS: nxt_st.prdata = {24'h000000, ctrl_rd};
        ADSQ_SEL_OFS: nxt_st.prdata = {24'h000000, sel_word(st_ff.ref_hold, st_ff.chan_hold)};
        ADSQ_RESULT_OFS: nxt_st.prdata = {22'h0, st_ff.result};
        ADSQ_STATUS_OFS: nxt_st.prdata = {22'h0, st_ff.first,
                                          st_ff.phase == ADSQ_CONV,
                                          sel_word(st_ff.ref_act, st_ff.chan_act)};
        default: nxt_st.prdata = 32'h00000000;
      endcase
    end
    if (complete && st_ff.phase == ADSQ_IDLE) begin
      nxt_st.phase = ADSQ_IDLE;
    end
  end

  // single register stage for the whole state
  // reset loads constants only; first is set so the next run is the long one
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '{phase: ADSQ_IDLE, ref_hold: ADSQ_SEL_RESET[7:6],
                 chan_hold: ADSQ_SEL_RESET[3:0], ref_act: ADSQ_SEL_RESET[7:6],
                 chan_act: ADSQ_SEL_RESET[3:0], enable: ADSQ_CTRL_RESET[7],
                 start: ADSQ_CTRL_RESET[6], free_run: ADSQ_CTRL_RESET[5],
                 done: ADSQ_CTRL_RESET[4], irq_en: ADSQ_CTRL_RESET[3],
                 presc: ADSQ_CTRL_RESET[2:0], first: 1'b1, div_cnt: 7'h00,
                 cyc: 5'h00, sampled: 10'h000, result: 10'h000,
                 code_s1: 11'h000, code_s2: 11'h000, prdata: 32'h00000000};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs toward the analog side and the interrupt controller
  // all come straight from state flops or one gate after them
  assign active_channel = st_ff.chan_act;
  assign active_reference = st_ff.ref_act;
  assign internal_ref_on = (st_ff.ref_act == ADSQ_REF_INT_2V56);
  assign converter_busy = st_ff.start;
  assign conv_irq = st_ff.done & st_ff.irq_en;

endmodule

/* testbench/adsq_seq_asserts.sv */
// port checker for the selection sequencer
// assumes prescale 0: one converter cycle is two mclk cycles
module adsq_seq_asserts
  import adsq_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sleep_enter,
  input wire adsq_sleep_type sleep_mode,
  input wire logic irq_ack,
  input wire logic [3:0] active_channel,
  input wire logic [1:0] active_reference,
  input wire logic internal_ref_on,
  input wire logic converter_busy,
  input wire logic conv_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic map;
  logic [3:0] chan_ff;
  logic [11:0] len_ff;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  assign map = paddr inside {ADSQ_CTRL_OFS, ADSQ_SEL_OFS, ADSQ_RESULT_OFS, ADSQ_STATUS_OFS};
  // last channel written, and length of the busy spell
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      chan_ff <= 4'h0;
      len_ff <= 12'h000;
    end else begin
      if (psel && penable && pwrite && paddr == ADSQ_SEL_OFS) chan_ff <= pwdata[3:0];
      len_ff <= converter_busy ? len_ff + 12'h001 : 12'h000;
    end
  end
  sequence s_sel_wr;
    psel && penable && pwrite && paddr == ADSQ_SEL_OFS && !converter_busy;
  endsequence
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_err_unmapped: assert property (psel && penable && !map |-> pslverr)
    else $error("no error on unmapped");
  a_err_mapped: assert property (psel && penable && map |-> !pslverr)
    else $error("error on mapped");
  a_ref_decode: assert property (
      internal_ref_on == (active_reference == ADSQ_REF_INT_2V56))
    else $error("ref decode");
  a_sel_track: assert property (
      s_sel_wr |-> ##2 (converter_busy || active_channel == chan_ff))
    else $error("no tracking");
  a_ack_clears: assert property (irq_ack && !converter_busy |=> !conv_irq)
    else $error("ack kept irq");
  a_conv_length: assert property ($fell(converter_busy) |-> len_ff >= 12'h01a)
    else $error("short conversion");
  a_sleep_other: assert property (
      sleep_enter && sleep_mode > ADSQ_SLEEP_NOISE && !converter_busy |=> !converter_busy)
    else $error("sleep start in wrong mode");
endmodule

bind adsq_sequencer adsq_seq_asserts chk_u (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .sleep_enter, .sleep_mode, .irq_ack, .active_channel,
  .active_reference, .internal_ref_on, .converter_busy, .conv_irq);

/* testbench/adc_selection_sequencer_bench.sv */
// self-checking bench for the selection sequencer
// assumes prescale 0: one converter cycle is two mclk cycles
module adc_selection_sequencer_bench
  import adsq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic sleep_enter = 0, irq_ack = 0, pready, pslverr, e;
  logic internal_ref_on, converter_busy, conv_irq;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q, s;
  logic [10:0] analog_code = 11'h000;
  logic [3:0] active_channel;
  logic [1:0] active_reference;
  adsq_sleep_type sleep_mode = ADSQ_SLEEP_IDLE;
  integer seed = 32'h2ae7;
  int errors = 0, n_tests = 0, cyc = 0, n;

  adsq_sequencer dut_u (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .analog_code, .sleep_enter, .sleep_mode, .irq_ack, .active_channel,
    .active_reference, .internal_ref_on, .converter_busy, .conv_irq);

  // clock, and a ceiling far above the ~450 cycles needed
  initial forever #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] y);
    n_tests++;
    if (y !== x) begin
      errors++;
      $display("[FAIL] %s exp %h got %h", nm, x, y);
    end
  endtask

  // one apb transfer; waits on pready, no fixed latency assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  // wait out a conversion; len 0 skips the length check
  task automatic conv(input int len);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (converter_busy !== 1'b0 && n < 4000);
    chk("conv wait", 1, n < 4000);
    if (len > 0) chk("len", 1, n >= 2 * len - 10 && n <= 2 * len + 3);
  endtask

  task automatic wirq();
    n = 0;
    while (conv_irq !== 1'b1 && n < 400) begin
      @(posedge mclk);
      n++;
    end
    chk("irq wait", 1, n < 400);
  endtask

  task automatic ack();
    irq_ack <= 1;
    @(posedge mclk);
    irq_ack <= 0;
    @(posedge mclk);
  endtask

  // over-range input must saturate rather than wrap
  function automatic logic [31:0] exp_res(input logic [10:0] c);
    return c[10] ? 32'h3ff : {22'h0, c[9:0]};
  endfunction

  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1;
    for (int i = 0; i < 3; i++) begin
      apb(0, 8'(4 * i), 0);
      chk("reset", 0, q);
    end
    apb(1, ADSQ_SEL_OFS, 32'hc5);
    repeat (3) @(posedge mclk);
    chk("chan", 5, active_channel);
    chk("intref", 1, internal_ref_on);
    apb(0, ADSQ_STATUS_OFS, 0);
    chk("status", 32'h2c5, q);
    $display("done: reset and tracking");
    analog_code <= 11'h4a5;
    apb(1, ADSQ_CTRL_OFS, 32'hc0);
    repeat (2) @(posedge mclk); // one converter cycle first
    apb(1, ADSQ_SEL_OFS, 32'h42);
    chk("locked", 5, active_channel);
    conv(25);
    chk("chan", 2, active_channel);
    apb(0, ADSQ_RESULT_OFS, 0);
    chk("res", exp_res(11'h4a5), q);
    apb(0, ADSQ_CTRL_OFS, 0);
    chk("ctrl", 32'h90, q);
    apb(0, ADSQ_STATUS_OFS, 0);
    chk("status", 32'h42, q);
    chk("slverr", 0, e);
    $display("done: first conversion");
    repeat (4) begin
      s = $random(seed);
      analog_code <= s[10:0];
      apb(1, ADSQ_SEL_OFS, {24'h0, s[15:14], 2'h0, s[19:16]});
      apb(1, ADSQ_CTRL_OFS, 32'hd0);
      conv(13);
      chk("chan", s[19:16], active_channel);
      chk("ref", s[15:14], active_reference);
      apb(0, ADSQ_RESULT_OFS, 0);
      chk("res", exp_res(s[10:0]), q);
    end
    $display("done: random conversions");
    apb(1, ADSQ_SEL_OFS, 32'h41);
    apb(1, ADSQ_CTRL_OFS, 32'hf8);
    wirq();
    apb(1, ADSQ_SEL_OFS, 32'hc3);
    chk("busy", 1, converter_busy);
    chk("old chan", 1, active_channel);
    ack();
    wirq();
    chk("period", 1, n < 30);
    chk("new chan", 3, active_channel);
    apb(1, ADSQ_CTRL_OFS, 32'h98);
    conv(0); // first result after the reference switch is left unread
    ack();
    $display("done: free running");
    for (int m = 0; m < 5; m++) begin
      sleep_mode <= adsq_sleep_type'(m);
      sleep_enter <= 1;
      @(posedge mclk);
      sleep_enter <= 0;
      repeat (2) @(posedge mclk);
      chk("sleep busy", m < 2, converter_busy);
      conv(m < 2 ? 13 : 0);
      chk("irq", m < 2, conv_irq);
      ack();
      apb(0, ADSQ_CTRL_OFS, 0);
      chk("ctrl", 32'h88, q);
    end
    $display("done: sleep");
    apb(0, 8'h10, 0);
    chk("unmapped", 0, q);
    chk("slverr", 1, e);
    $display("done: unmapped");
    print_verdict();
  end
endmodule
